// [common/vic_pkg.sv]
// Constants and carrier types for the vectored interrupt controller.
`default_nettype none
package vic_pkg;
  localparam int unsigned NUM_SRC  = 32;
  localparam int unsigned STK_DEPTH = 8;
  localparam int unsigned SP_W     = 4;
  // Byte offsets of the register map.
  localparam logic [8:0] OFS_SMR   = 9'h000;
  localparam logic [8:0] OFS_SVR   = 9'h080;
  localparam logic [8:0] OFS_IVR   = 9'h100;
  localparam logic [8:0] OFS_FVR   = 9'h104;
  localparam logic [8:0] OFS_ISR   = 9'h108;
  localparam logic [8:0] OFS_IPR   = 9'h10c;
  localparam logic [8:0] OFS_IMR   = 9'h110;
  localparam logic [8:0] OFS_CISR  = 9'h114;
  localparam logic [8:0] OFS_IECR  = 9'h120;
  localparam logic [8:0] OFS_IDCR  = 9'h124;
  localparam logic [8:0] OFS_ICCR  = 9'h128;
  localparam logic [8:0] OFS_ISCR  = 9'h12c;
  localparam logic [8:0] OFS_EOICR = 9'h130;
  localparam logic [8:0] OFS_SPU   = 9'h134;
  // Implemented sources and those fed from pins.
  localparam logic [31:0] IMPL_MASK = 32'h0007_01ff;
  localparam logic [31:0] EXT_MASK  = 32'h0007_0001;
  // Mode field layout: priority in 2:0, trigger type in 6:5.
  localparam int unsigned PRIO_LSB = 0;
  localparam int unsigned TYPE_LSB = 5;
  localparam logic [7:0]  SMR_WMASK = 8'h67;
  localparam logic [7:0]  SMR_RST   = 8'h00;
  localparam logic [31:0] VEC_RST   = 32'h0000_0000;
  localparam int unsigned SW_SRC    = 1;
  localparam int unsigned FAST_SRC  = 0;
  typedef struct packed {
    logic [8:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } avmm_req_t;
  typedef struct packed {
    logic [2:0] lvl;
    logic [4:0] id;
  } ctx_t;
endpackage : vic_pkg
`default_nettype wire

// [rtl/vectored_int_ctrl.sv]
// Vectored 8-level priority interrupt controller with Avalon-MM slave.
//
// Our own choices: the register offsets and the Avalon-MM interface to the registers.
`default_nettype none

// Contract
// - Vector read returns handler vector of current highest-priority source.
// - Standard sources carry priority 7 (highest) down to 0 (lowest).
// - Equal priority ties go to the smallest source number.
// - Current level is captured from the source chosen at vector read.
// - A newer higher source before the vector read wins that read.
// - Higher source after the read re-raises request; next read stacks level.
// - End-of-service write pops the last stacked level, if any.
// - Normal-mode vector read drops request and clears edge source.
// - Enable and disable commands set the readable per-source mask.
// - Set and clear commands pend or clear edge-triggered sources.
// - The fast input, or a set command when source zero is edge-triggered, drives the fast request, bypassing arbitration.
// - Source zero's mode selects the fast input's edge or level trigger.
// - Fast vector read returns source zero's handler vector.
// - Request withdrawn before the vector read yields the spurious vector.
// - Vector read with nothing pending also yields the spurious vector.
// - Spurious state blocks both requests until end-of-service write.
// - Protect mode: read only selects; write stacks and acknowledges.
// - Protect mode: source id and context change only on vector write.
// - Normal mode vector write has no effect.
// - Sources: fast 0, software 1, 2 to 8 internal, 16 to 18 pins.
// - Two-bit trigger type: low, falling, high, rising; internal use bit 0.
module vectored_int_ctrl (
  // Clock and reset.
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Register bus.
  input  wire vic_pkg::avmm_req_t avs,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  // Interrupt sources.
  input  wire logic              fast_interrupt_input,
  input  wire logic [2:0]        ext_irq_in,
  input  wire logic [6:0]        periph_irq_in,
  input  wire logic              debug_protect_setting,
  // Processor request lines, active high.
  output logic                   std_irq_request_line,
  output logic                   fast_irq_request_line
);
  import vic_pkg::*;

  // Sources are first reduced to one active-high bit each, then gated
  // by the enable mask and ranked by a plain priority scan. The scan is
  // combinational so that a vector read always sees the newest winner,
  // which is what lets a late higher source take over before the read.
  // The cost is a long comparison chain over all standard sources; at
  // this clock rate it fits in one cycle, but a faster build would need
  // a registered winner and one more wait state.

  // Register storage.
  logic [7:0]   smr [NUM_SRC];
  logic [31:0]  svr [NUM_SRC];
  logic [31:0]  spu;
  logic [31:0]  mask;
  logic [31:0]  edge_pend;
  logic [31:0]  prev_act;
  logic [3:0]   sync1;
  logic [3:0]   sync2;
  logic         prot1;
  logic         prot2;
  logic         ack;
  ctx_t         cur;
  ctx_t         stk [STK_DEPTH];
  logic [SP_W-1:0] sp;
  logic         spur;
  logic         hold_ok;
  ctx_t         hold;

  // Every access costs exactly one wait cycle. The access is taken on
  // the first edge, where all side effects happen, and the registered
  // read data stand at the second edge. The ack flop stops a held
  // request from being taken twice, so a master that keeps its strobe
  // up through the wait cycle does not repeat a read with side effects.
  // Bus decode.
  wire logic       req = avs.read | avs.write;
  wire logic       acc = req & ~ack;
  wire logic       rd  = acc & avs.read;
  wire logic       wr  = acc & avs.write;
  wire logic [8:0] a   = avs.address;
  wire logic [31:0] wd = avs.writedata;
  wire logic [4:0] idx = a[6:2];
  wire logic in_smr = (a[8:7] == 2'h0);
  wire logic in_svr = (a[8:7] == 2'h1);
  wire logic idx_ok = IMPL_MASK[idx];

  wire logic ivr_rd   = rd & (a == OFS_IVR);
  wire logic ivr_wr   = wr & (a == OFS_IVR);
  wire logic fvr_rd   = rd & (a == OFS_FVR);
  wire logic iecr_wr  = wr & (a == OFS_IECR);
  wire logic idcr_wr  = wr & (a == OFS_IDCR);
  wire logic iccr_wr  = wr & (a == OFS_ICCR);
  wire logic iscr_wr  = wr & (a == OFS_ISCR);
  wire logic eoi_wr   = wr & (a == OFS_EOICR);
  wire logic spu_wr   = wr & (a == OFS_SPU);
  wire logic smr_wr   = wr & in_smr & idx_ok;
  wire logic svr_wr   = wr & in_svr & idx_ok;

  // Each access is answered one cycle after it is taken.
  assign avs_waitrequest = acc;

  // Raw source levels; pins pass two flops first.
  wire logic prot = prot2;
  logic [31:0] raw;
  assign raw = {13'h0, sync2[3:1], 7'h0,
                periph_irq_in, 1'b0, sync2[0]};

  // Trigger decode per source.
  logic [31:0] is_edge;
  logic [31:0] inv;
  logic [31:0] act;
  logic [31:0] edge_ev;
  logic [31:0] pend;
  logic [31:0] live;

  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      is_edge[i] = smr[i][TYPE_LSB];
      // Pin sources pick polarity with the high type bit.
      inv[i] = EXT_MASK[i] & ~smr[i][TYPE_LSB+1];
    end
  end

  assign act     = raw ^ inv;
  assign edge_ev = act & ~prev_act & is_edge;
  // Level sources follow the input; edges stay latched.
  assign pend = IMPL_MASK &
                ((edge_pend & is_edge) |
                 (act & ~is_edge));
  assign live = pend & mask;

  // The fast source is kept out of the scan on purpose. It has its own
  // request line and vector, and letting it rank here would let a fast
  // event steal a standard vector read.
  // Reserved sources never become pending because the implemented mask
  // gates them, so their mode and vector storage cannot matter.
  // Arbitration among standard sources.
  logic       best_ok;
  logic [4:0] best_id;
  logic [2:0] best_pr;

  always_comb begin
    best_ok = 1'b0;
    best_id = 5'h0;
    best_pr = 3'h0;
    // Source zero never takes part here.
    for (int i = 1; i < NUM_SRC; i++) begin
      // Strictly greater keeps the lowest number on ties.
      if (live[i] && (!best_ok ||
          smr[i][PRIO_LSB +: 3] > best_pr)) begin
        best_ok = 1'b1;
        best_id = 5'(i);
        best_pr = smr[i][PRIO_LSB +: 3];
      end
    end
  end

  wire logic idle = (sp == '0);
  // A source is serviceable if it beats the level in service.
  wire logic take = best_ok & ~spur &
                    (idle | (best_pr > cur.lvl));
  wire logic fast_ok = live[FAST_SRC] & ~spur;

  wire ctx_t best_ctx = '{lvl: best_pr, id: best_id};
  wire logic [31:0] ivr_val =
    take ? svr[best_id] : spu;
  wire logic [31:0] fvr_val =
    fast_ok ? svr[FAST_SRC] : spu;

  // In normal mode the read itself acknowledges and stacks. In protect
  // mode the read only records its choice in hold, and the following
  // vector write applies it; a lone read therefore leaves the context
  // and the status identifier untouched. A second read between read
  // and write simply overwrites hold with a newer choice.
  // A write in normal mode only drops hold, so it cannot replay a stale
  // choice later.
  // Context actions: a push acknowledges the chosen source.
  wire logic push_n = ivr_rd & ~prot & take;
  wire logic push_p = ivr_wr & prot & hold_ok;
  wire logic push   = push_n | push_p;
  wire ctx_t push_ctx = push_p ? hold : best_ctx;
  wire logic full = (sp == SP_W'(STK_DEPTH));

  wire logic spur_set =
    (ivr_rd & ~prot & ~take) |
    (ivr_wr & prot & ~hold_ok) |
    (fvr_rd & ~prot & ~fast_ok);

  wire logic pop = eoi_wr & ~spur & ~idle;

  // One-hot clear of the acknowledged edge source.
  logic [31:0] ack_clr;
  always_comb begin
    ack_clr = '0;
    if (push) begin
      ack_clr[push_ctx.id] = 1'b1;
    end
    if (fvr_rd && !prot && fast_ok) begin
      ack_clr[FAST_SRC] = 1'b1;
    end
  end

  wire logic [31:0] set_hit =
    iscr_wr ? (wd & IMPL_MASK & is_edge) : '0;
  wire logic [31:0] clr_hit =
    (iccr_wr ? wd : '0) | ack_clr;

  // Read data selection.
  wire logic [31:0] smr_rd =
    idx_ok ? {24'h0, smr[idx]} : '0;
  wire logic [31:0] svr_rd = idx_ok ? svr[idx] : '0;
  wire logic [31:0] isr_rd = {27'h0, idle ? 5'h0 : cur.id};
  wire logic [31:0] cisr_rd =
    {30'h0, std_irq_request_line, fast_irq_request_line};
  wire logic [31:0] rd_val =
    in_smr            ? smr_rd  :
    in_svr            ? svr_rd  :
    (a == OFS_IVR)    ? ivr_val :
    (a == OFS_FVR)    ? fvr_val :
    (a == OFS_ISR)    ? isr_rd  :
    (a == OFS_IPR)    ? pend    :
    (a == OFS_IMR)    ? mask    :
    (a == OFS_CISR)   ? cisr_rd :
    (a == OFS_SPU)    ? spu     :
                        32'h0;

  // Bus answer.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack          <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      ack <= acc;
      if (rd) begin
        avs_readdata <= rd_val;
      end
    end
  end

  // Pin inputs and the protect setting pass two flops before use. The
  // fast and external sources thus lag their pins by two cycles, plus
  // one more for edge detection; internal sources are on this clock
  // and are used directly.
  // Pin synchronisers.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      prot1 <= 1'b0;
      prot2 <= 1'b0;
    end else begin
      sync1 <= {ext_irq_in, fast_interrupt_input};
      sync2 <= sync1;
      prot1 <= debug_protect_setting;
      prot2 <= prot1;
    end
  end

  // Mode and vector storage.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        smr[i] <= SMR_RST;
        svr[i] <= VEC_RST;
      end
      spu <= VEC_RST;
    end else begin
      if (smr_wr) begin
        smr[idx] <= wd[7:0] & SMR_WMASK;
      end
      if (svr_wr) begin
        svr[idx] <= wd;
      end
      if (spu_wr) begin
        spu <= wd;
      end
    end
  end

  // Enable mask.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mask <= 32'h0;
    end else if (iecr_wr) begin
      mask <= mask | (wd & IMPL_MASK);
    end else if (idcr_wr) begin
      mask <= mask & ~wd;
    end
  end

  // Edge latches: a new edge or set wins over a clear.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      edge_pend <= 32'h0;
      prev_act  <= 32'h0;
    end else begin
      prev_act  <= act;
      edge_pend <= IMPL_MASK & is_edge &
                   (edge_ev | set_hit |
                    (edge_pend & ~clr_hit));
    end
  end

  // The stack saves the outgoing context on every push, the idle one
  // included, so the pop after the outermost handler restores level
  // zero with no special case. When the stack is full a further push
  // is dropped, yet still clears the chosen edge source and lowers the request. Depth
  // eight matches the eight levels, so a strictly rising chain of
  // nested handlers cannot overflow it.
  // Priority stack and current context.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur <= '0;
      sp  <= '0;
      for (int i = 0; i < STK_DEPTH; i++) begin
        stk[i] <= '0;
      end
    end else if (push && !full) begin
      // The outgoing context is saved even when idle.
      stk[sp[SP_W-2:0]] <= cur;
      cur <= push_ctx;
      sp  <= sp + SP_W'(1);
    end else if (pop) begin
      cur <= stk[sp[SP_W-2:0] - 3'h1];
      sp  <= sp - SP_W'(1);
    end
  end

  // The spurious flag is set by any normal-mode vector read, or protect-mode vector write, that finds nothing to
  // serve. While it is set neither request line may rise, and the next
  // end-of-service write only clears it, without popping the stack,
  // because nothing was pushed for the spurious fetch.
  // Spurious state and protect-mode hold.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      spur    <= 1'b0;
      hold_ok <= 1'b0;
      hold    <= '0;
    end else begin
      if (spur_set) begin
        spur <= 1'b1;
      end else if (eoi_wr) begin
        spur <= 1'b0;
      end
      // A protect-mode read only remembers its choice.
      if (ivr_rd && prot) begin
        hold_ok <= take;
        hold    <= best_ctx;
      end else if (ivr_wr) begin
        hold_ok <= 1'b0;
      end
    end
  end

  // Both request lines are registered so that the core sees no glitch
  // from the combinational scan. The standard line drops at the same edge
  // that takes the acknowledging fetch.
  // Request lines; the spurious state silences both.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      std_irq_request_line  <= 1'b0;
      fast_irq_request_line <= 1'b0;
    end else begin
      std_irq_request_line  <= take & ~push;
      fast_irq_request_line <= fast_ok;
    end
  end

endmodule : vectored_int_ctrl
`default_nettype wire

// [dv/vectored_int_ctrl_chk.sv]
// Port-level assertions for the vectored interrupt controller.
`default_nettype none
module vectored_int_ctrl_chk (
  // Clock and reset.
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // Register bus.
  input  wire vic_pkg::avmm_req_t avs,
  input  wire logic [31:0]        avs_readdata,
  input  wire logic               avs_waitrequest,
  // Interrupt sources.
  input  wire logic               fast_interrupt_input,
  input  wire logic [2:0]         ext_irq_in,
  input  wire logic [6:0]         periph_irq_in,
  input  wire logic               debug_protect_setting,
  // Request lines.
  input  wire logic               std_irq_request_line,
  input  wire logic               fast_irq_request_line
);
  import vic_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire taken = (avs.read | avs.write) & avs_waitrequest;
  wire vector_fetch_short   = taken & (avs.address == OFS_IVR);
  wire std   = std_irq_request_line;
  wire quiet = !std_irq_request_line && !fast_irq_request_line;
  // The mode pin is synchronised, so it must settle before a check applies.
  sequence normal_s;
    !debug_protect_setting [*4];
  endsequence
  sequence protect_s;
    debug_protect_setting [*4];
  endsequence
  AST_ONE_WAIT: assert property (taken |=> !avs_waitrequest)
    else $error("bus access not answered after one wait cycle");
  AST_RDATA_HOLD: assert property (!(taken && avs.read) |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  AST_RST_QUIET: assert property ($fell(rst) |-> quiet)
    else $error("request line high out of reset");
  AST_IVR_ACK: assert property (
    normal_s ##0 (vector_fetch_short && avs.read && std) |-> ##[1:2] !std)
    else $error("vector read did not drop the request");
  AST_PROT_HOLD: assert property (
    protect_s ##0 (vector_fetch_short && avs.read && std) |=> std [*2])
    else $error("protected vector read acknowledged the request");
  AST_PROT_ACK: assert property (
    protect_s ##0 (vector_fetch_short && avs.write && std) |-> ##[1:2] !std)
    else $error("protected vector write did not acknowledge");
  AST_NORM_WR: assert property (
    normal_s ##0 (vector_fetch_short && avs.write && std) |=> std [*2])
    else $error("vector write had an effect in normal mode");
  AST_SPUR: assert property (
    normal_s ##0 (vector_fetch_short && avs.read && quiet) |=> quiet [*2])
    else $error("request raised during spurious handling");
endmodule : vectored_int_ctrl_chk

bind vectored_int_ctrl vectored_int_ctrl_chk vectored_int_ctrl_chk_inst (
  .ref_clk(ref_clk), .rst(rst), .avs(avs), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .fast_interrupt_input(fast_interrupt_input), .ext_irq_in(ext_irq_in),
  .periph_irq_in(periph_irq_in),
  .debug_protect_setting(debug_protect_setting),
  .std_irq_request_line(std_irq_request_line),
  .fast_irq_request_line(fast_irq_request_line));
`default_nettype wire

// [dv/core_model.sv]
// Processor core model that counts entries into its standard handler.
`default_nettype none
module core_model (
  // Clock and reset.
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Request line and handler entry count.
  input  wire logic       irq_line,
  output logic [7:0]      irq_entries
);
  timeunit 1ns;
  timeprecision 1ps;
  logic seen;
  // Each rise is one entry; the bench's handler then reads the vector.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      seen <= 1'b0;
      irq_entries <= 8'h00;
    end else begin
      seen <= irq_line;
      if (irq_line && !seen) irq_entries <= irq_entries + 8'h01;
    end
  end
endmodule : core_model
`default_nettype wire

// [dv/vectored_int_ctrl_tb.sv]
// Self-checking testbench for the vectored interrupt controller.
`default_nettype none
module vectored_int_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import vic_pkg::*;
  logic        ref_clk, rst, fir, dps, std_l, fast_l, wt;
  avmm_req_t   avs;
  logic [31:0] rdata, rd, sv [9];
  logic [2:0]  ext, pr [9];
  logic [6:0]  per;
  logic [7:0]  ent;
  int          seed, error_cnt, n_tests, win;
  vectored_int_ctrl vectored_int_ctrl_inst (.ref_clk(ref_clk), .rst(rst),
    .avs(avs), .avs_readdata(rdata), .avs_waitrequest(wt),
    .fast_interrupt_input(fir), .ext_irq_in(ext), .periph_irq_in(per),
    .debug_protect_setting(dps), .std_irq_request_line(std_l),
    .fast_irq_request_line(fast_l));
  core_model core_model_inst (.ref_clk(ref_clk), .rst(rst),
    .irq_line(std_l), .irq_entries(ent));
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [8:0] a,
                     input logic [31:0] d = 32'h0);
    int k = 0;
    @(posedge ref_clk);
    avs <= '{a, !w, w, d};
    // Waitrequest is sampled at the rising edge itself; the request is
    // released at the edge where it is seen low, never earlier.
    do begin
      @(posedge ref_clk);
      k++;
    end while (wt !== 1'b0 && k < 50);
    if (wt !== 1'b0) begin
      error_cnt++;
      tally_and_finish();
    end
    rd = rdata;
    avs <= '0;
  endtask : bus
  // Bounded wait for a request line to reach the given level.
  task automatic wait_ln(input logic f, input logic v);
    int k = 0;
    do begin
      @(negedge ref_clk);
      k++;
    end while ((f ? fast_l : std_l) !== v && k < 20);
    chk({31'h0, f ? fast_l : std_l}, {31'h0, v});
    if ((f ? fast_l : std_l) !== v) tally_and_finish();
    @(posedge ref_clk);
  endtask : wait_ln
  function automatic int best(input logic [6:0] p);
    best = 0;
    for (int s = 8; s >= 2; s--)
      if (p[s-2] && (best == 0 || pr[s] >= pr[best])) best = s;
  endfunction : best
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    seed = 32'hf86afc07;
    rst = 1'b1;
    avs = '0;
    {fir, dps, per, ext, error_cnt, n_tests} = '0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    bus(0, OFS_IMR); chk(rd, 32'h0);
    bus(0, 9'h118); chk(rd, 32'h0);
    bus(1, OFS_SPU, 32'h5a5a_0001);
    bus(0, OFS_IVR); chk(rd, 32'h5a5a_0001);
    bus(1, OFS_EOICR);
    $display("test spurious done");
    bus(1, OFS_IECR, 32'h1fc);
    bus(0, OFS_IMR); chk(rd, 32'h1fc);
    // The first pass ties every source at the top level.
    for (int i = 0; i < 8; i++) begin
      for (int s = 2; s < 9; s++) begin
        pr[s] = (i == 0) ? 3'h7 : 3'($random(seed));
        sv[s] = $random(seed);
        bus(1, OFS_SMR + 9'(4 * s), {29'h0, pr[s]});
        bus(1, OFS_SVR + 9'(4 * s), sv[s]);
      end
      per <= (i == 0) ? 7'h7e : 7'($random(seed)) | 7'h40;
      wait_ln(0, 1);
      win = best(per);
      bus(0, OFS_IVR); chk(rd, sv[win]);
      bus(0, OFS_ISR); chk(rd, 32'(win));
      per <= '0;
      bus(1, OFS_EOICR);
    end
    chk({24'h0, ent}, 32'h8);
    $display("test priority done");
    bus(1, OFS_SMR + 9'h08, 32'h1);
    bus(1, OFS_SMR + 9'h0c, 32'h5);
    bus(1, OFS_SMR + 9'h10, 32'h3);
    per <= 7'h01;
    wait_ln(0, 1);
    bus(0, OFS_IVR); chk(rd, sv[2]);
    per <= 7'h03;
    wait_ln(0, 1);
    bus(0, OFS_IVR); chk(rd, sv[3]);
    per <= 7'h05;
    bus(1, OFS_EOICR);
    wait_ln(0, 1);
    bus(0, OFS_IVR); chk(rd, sv[4]);
    per <= '0;
    bus(1, OFS_EOICR);
    bus(1, OFS_EOICR);
    $display("test nesting done");
    bus(1, OFS_SMR + 9'h04, 32'h26);
    bus(1, OFS_SVR + 9'h04, 32'h0000_1e1e);
    bus(1, OFS_IECR, 32'h2);
    bus(1, OFS_ISCR, 32'h2);
    bus(0, OFS_IPR); chk(rd & 32'h2, 32'h2);
    wait_ln(0, 1);
    bus(0, OFS_IVR); chk(rd, 32'h0000_1e1e);
    bus(0, OFS_IPR); chk(rd & 32'h2, 32'h0);
    bus(1, OFS_EOICR);
    bus(1, OFS_ISCR, 32'h2);
    bus(1, OFS_ICCR, 32'h2);
    bus(0, OFS_IPR); chk(rd & 32'h2, 32'h0);
    $display("test software source done");
    per <= 7'h01;
    wait_ln(0, 1);
    bus(1, OFS_IVR);
    dps <= 1'b1;
    repeat (4) @(posedge ref_clk);
    bus(0, OFS_IVR); chk(rd, sv[2]);
    bus(0, OFS_ISR); chk(rd, 32'h0);
    bus(1, OFS_IVR);
    wait_ln(0, 0);
    bus(0, OFS_ISR); chk(rd, 32'h2);
    per <= '0;
    dps <= 1'b0;
    bus(1, OFS_EOICR);
    $display("test protect done");
    sv[0] = $random(seed);
    bus(1, OFS_SVR, sv[0]);
    bus(1, OFS_SMR, 32'h40);
    bus(1, OFS_IECR, 32'h1);
    fir <= 1'b1;
    wait_ln(1, 1);
    chk({31'h0, std_l}, 32'h0);
    bus(0, OFS_FVR); chk(rd, sv[0]);
    fir <= 1'b0;
    wait_ln(1, 0);
    $display("test fast done");
    tally_and_finish();
  end
endmodule : vectored_int_ctrl_tb
`default_nettype wire
